// ### bench/cim_pin_model.sv
// Pin sources for the counter: source, gate, direction, sample clock.
// Assumes the bench clock; each level is held for HOLD cycles.
`timescale 1ns/1ns
module cim_pin_model (
  input  wire logic clock,
  output logic      sourcePin,
  output logic      gatePin,
  output logic      dirPin,
  output logic      sampleClkPin
);
  // Above the 2-cycle minimum so the synchroniser never misses a level
  localparam int HOLD = 4;

  // Quiet pins at time zero
  initial begin
    sourcePin = 1'b0;
    gatePin = 1'b0;
    dirPin = 1'b0;
    sampleClkPin = 1'b0;
  end

  // Pins change 1 ns after an edge, never on it
  task automatic holdLevel();
    repeat (HOLD) @(posedge clock);
    #1;
  endtask

  task automatic srcPulses(input int n);
    for (int i = 0; i < n; i++) begin
      holdLevel();
      sourcePin = 1'b1;
      holdLevel();
      sourcePin = 1'b0;
    end
    holdLevel();
  endtask

  task automatic setSource(input logic v);
    holdLevel();
    sourcePin = v;
    holdLevel();
  endtask

  task automatic setGate(input logic v);
    holdLevel();
    gatePin = v;
    holdLevel();
  endtask

  task automatic setDir(input logic v);
    holdLevel();
    dirPin = v;
    holdLevel();
  endtask

  task automatic setSample(input logic v);
    holdLevel();
    sampleClkPin = v;
    holdLevel();
  endtask

  // One full sample clock period, rise first
  task automatic sampleTick();
    setSample(1'b1);
    setSample(1'b0);
  endtask
endmodule

// ### bench/testbench.sv
// Bench for the counter input engine: pins from the pin model, config as ports.
// Assumes the design reads config every cycle and pins with 3-cycle latency.
`timescale 1ns/1ns
module testbench
  import cim_pkg::*;
;
  logic              clock;
  logic              rst;
  logic              sourcePin;
  logic              gatePin;
  logic              dirPin;
  logic              sampleClkPin;
  logic              arm;
  logic              disarm;
  logic [MODE_W-1:0] mode;
  logic              sourceFalling;
  logic              sampleFalling;
  logic              pauseOnHigh;
  logic              pauseEnable;
  logic              measureLow;
  logic              first_phase_select;
  logic              semi_period_first_phase_select;
  logic [DIR_W-1:0]  dirSelect;
  logic [CNT_W-1:0]  initialCount;
  logic [CNT_W-1:0]  countValue;
  logic              armed;
  logic              done;
  logic              overrun;
  logic              dropped;
  logic              streamValid;
  logic              streamReady;
  logic [DATA_W-1:0] streamData;
  int                numErrors = 0;
  int                cmpCount = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  cim_pin_model i_pins (.clock(clock), .sourcePin(sourcePin), .gatePin(gatePin),
    .dirPin(dirPin), .sampleClkPin(sampleClkPin));

  cim_counter i_dut (.clock(clock), .rst(rst), .sourcePin(sourcePin), .gatePin(gatePin),
    .dirPin(dirPin), .sampleClkPin(sampleClkPin), .arm(arm), .disarm(disarm),
    .mode(mode), .sourceFalling(sourceFalling), .sampleFalling(sampleFalling),
    .pauseOnHigh(pauseOnHigh), .pauseEnable(pauseEnable), .measureLow(measureLow),
    .first_phase_select(first_phase_select),
    .semi_period_first_phase_select(semi_period_first_phase_select),
    .dirSelect(dirSelect), .initialCount(initialCount), .countValue(countValue),
    .armed(armed), .done(done), .overrun(overrun), .dropped(dropped),
    .streamValid(streamValid), .streamReady(streamReady), .streamData(streamData));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, the one exit of the run
  task automatic end_of_test();
    if (numErrors == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    cmpCount++;
    if (ok !== 1'b1) begin
      numErrors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Four cycles cover pin sync plus the count update
  task automatic checkCnt(input logic [CNT_W-1:0] exp);
    repeat (4) @(posedge clock);
    #1;
    check(countValue === exp, "count value");
  endtask

  task automatic checkNoWord();
    repeat (6) @(posedge clock);
    #1;
    check(streamValid === 1'b0, "unexpected stream word");
  endtask

  // Word stands until taken; ready is held up across exactly one edge
  task automatic popWord(input logic [CNT_W-1:0] exp, input logic useFlag,
                         input logic flag);
    int n;
    n = 0;
    // One edge first, so back-to-back calls never retoggle ready in one step
    @(posedge clock);
    #1;
    while (streamValid !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 200) begin
      check(1'b0, "stream word timeout");
      end_of_test();
    end
    check(streamData[CNT_W-1:0] === exp, "stream count");
    if (useFlag) begin
      check(streamData[CNT_W] === flag, "stream phase flag");
    end
    streamReady = 1'b1;
    @(posedge clock);
    #1;
    streamReady = 1'b0;
  endtask

  // Disarm, then arm in the given mode with a start value
  task automatic startMode(input logic [MODE_W-1:0] m, input logic [CNT_W-1:0] init);
    disarm = 1'b1;
    @(posedge clock);
    #1;
    disarm = 1'b0;
    mode = m;
    initialCount = init;
    @(posedge clock);
    #1;
    arm = 1'b1;
    @(posedge clock);
    #1;
    arm = 1'b0;
  endtask

  task automatic dirCase(input logic [DIR_W-1:0] sel, input logic pin,
                         input logic [CNT_W-1:0] exp);
    dirSelect = sel;
    i_pins.setDir(pin);
    startMode(MODE_EDGE_DEMAND, 32'h0000_0008);
    i_pins.srcPulses(3);
    checkCnt(exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    arm = 1'b0;
    disarm = 1'b0;
    mode = MODE_EDGE_DEMAND;
    sourceFalling = 1'b0;
    sampleFalling = 1'b0;
    pauseOnHigh = 1'b0;
    pauseEnable = 1'b0;
    measureLow = 1'b0;
    first_phase_select = 1'b0;
    semi_period_first_phase_select = 1'b0;
    dirSelect = DIR_UP;
    initialCount = CNT_RESET;
    streamReady = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    // Edges before arming are ignored
    i_pins.srcPulses(2);
    checkCnt(CNT_RESET);
    startMode(MODE_EDGE_DEMAND, 32'h0000_000A);
    checkCnt(32'h0000_000A);
    check(armed === 1'b1, "armed");
    i_pins.srcPulses(5);
    checkCnt(32'h0000_000F);
    checkCnt(32'h0000_000F);
    // Falling edges only
    sourceFalling = 1'b1;
    startMode(MODE_EDGE_DEMAND, CNT_RESET);
    i_pins.setSource(1'b1);
    checkCnt(CNT_RESET);
    i_pins.setSource(1'b0);
    checkCnt(32'h0000_0001);
    sourceFalling = 1'b0;
    dirCase(DIR_UP, 1'b0, 32'h0000_000B);
    dirCase(DIR_DN, 1'b1, 32'h0000_0005);
    dirCase(DIR_EXT, 1'b1, 32'h0000_000B);
    dirCase(DIR_EXT, 1'b0, 32'h0000_0005);
    // Wrap past the top of the 32-bit range
    dirSelect = DIR_UP;
    startMode(MODE_EDGE_DEMAND, 32'hFFFF_FFFE);
    i_pins.srcPulses(3);
    checkCnt(32'h0000_0001);
    // Pause on high gate, then on low gate
    pauseEnable = 1'b1;
    pauseOnHigh = 1'b1;
    startMode(MODE_EDGE_DEMAND, CNT_RESET);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(3);
    checkCnt(CNT_RESET);
    i_pins.setGate(1'b0);
    i_pins.srcPulses(2);
    checkCnt(32'h0000_0002);
    pauseOnHigh = 1'b0;
    startMode(MODE_EDGE_DEMAND, CNT_RESET);
    i_pins.srcPulses(2);
    checkCnt(CNT_RESET);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(1);
    checkCnt(32'h0000_0001);
    pauseEnable = 1'b0;
    // Sampled edge count stays cumulative; only the selected sample clock edge samples, rising then falling
    startMode(MODE_EDGE_SCLK, CNT_RESET);
    i_pins.srcPulses(3);
    i_pins.setSample(1'b1);
    popWord(32'h0000_0003, 1'b0, 1'b0);
    i_pins.srcPulses(2);
    i_pins.setSample(1'b0);
    checkNoWord();
    i_pins.setSample(1'b1);
    popWord(32'h0000_0005, 1'b0, 1'b0);
    sampleFalling = 1'b1;
    startMode(MODE_EDGE_SCLK, CNT_RESET);
    i_pins.srcPulses(1);
    i_pins.setSample(1'b0);
    popWord(32'h0000_0001, 1'b0, 1'b0);
    i_pins.setSample(1'b1);
    checkNoWord();
    i_pins.setSample(1'b0);
    popWord(32'h0000_0001, 1'b0, 1'b0);
    sampleFalling = 1'b0;
    // Sink stalls: two words held, third lost
    startMode(MODE_EDGE_SCLK, CNT_RESET);
    i_pins.srcPulses(1);
    for (int i = 0; i < 3; i++) begin
      i_pins.sampleTick();
    end
    check(dropped === 1'b1, "dropped flag");
    popWord(32'h0000_0001, 1'b0, 1'b0);
    popWord(32'h0000_0001, 1'b0, 1'b0);
    checkNoWord();
    // Pulse width, armed inside an active pulse; high pulses, then low pulses
    startMode(MODE_PW_IMPL, CNT_RESET);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    checkNoWord();
    i_pins.setGate(1'b1);
    i_pins.srcPulses(3);
    i_pins.setGate(1'b0);
    popWord(32'h0000_0003, 1'b0, 1'b0);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(1);
    i_pins.setGate(1'b0);
    popWord(32'h0000_0001, 1'b0, 1'b0);
    measureLow = 1'b1;
    startMode(MODE_PW_IMPL, CNT_RESET);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b1);
    checkNoWord();
    i_pins.setGate(1'b0);
    i_pins.srcPulses(4);
    i_pins.setGate(1'b1);
    popWord(32'h0000_0004, 1'b0, 1'b0);
    i_pins.setGate(1'b0);
    measureLow = 1'b0;
    // Single pulse width stops after one word
    startMode(MODE_PW_SINGLE, CNT_RESET);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    popWord(32'h0000_0002, 1'b0, 1'b0);
    check(done === 1'b1, "done");
    i_pins.setGate(1'b1);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    checkNoWord();
    // Sample-clocked pulse width and overrun
    startMode(MODE_PW_SCLK, CNT_RESET);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(3);
    i_pins.setGate(1'b0);
    i_pins.sampleTick();
    popWord(32'h0000_0003, 1'b0, 1'b0);
    check(overrun === 1'b0, "overrun early");
    i_pins.sampleTick();
    check(overrun === 1'b1, "overrun missing");
    // Sample-clocked pulse: high word then low word
    startMode(MODE_PULSE_SCLK, CNT_RESET);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    i_pins.srcPulses(3);
    i_pins.setGate(1'b1);
    i_pins.sampleTick();
    popWord(32'h0000_0002, 1'b1, 1'b1);
    popWord(32'h0000_0003, 1'b1, 1'b0);
    i_pins.sampleTick();
    check(overrun === 1'b1, "pulse overrun missing");
    // Implicit pulse, high phase first; edges before the start edge unseen
    first_phase_select = 1'b1;
    i_pins.setGate(1'b0);
    startMode(MODE_PULSE_IMPL, CNT_RESET);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    popWord(32'h0000_0002, 1'b1, 1'b1);
    i_pins.srcPulses(3);
    i_pins.setGate(1'b1);
    popWord(32'h0000_0003, 1'b1, 1'b0);
    // Semi-period, low phase first; sample clock has no effect
    startMode(MODE_SEMI_IMPL, CNT_RESET);
    i_pins.srcPulses(1);
    i_pins.setGate(1'b0);
    i_pins.srcPulses(4);
    i_pins.setGate(1'b1);
    popWord(32'h0000_0004, 1'b1, 1'b0);
    i_pins.srcPulses(1);
    i_pins.sampleTick();
    checkNoWord();
    i_pins.setGate(1'b0);
    popWord(32'h0000_0001, 1'b1, 1'b1);
    // Semi-period, high phase first, from a nonzero start value
    semi_period_first_phase_select = 1'b1;
    startMode(MODE_SEMI_IMPL, 32'h0000_0003);
    i_pins.setGate(1'b1);
    i_pins.srcPulses(2);
    i_pins.setGate(1'b0);
    popWord(32'h0000_0005, 1'b1, 1'b1);
    disarm = 1'b1;
    @(posedge clock);
    #1;
    disarm = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(armed === 1'b0, "still armed");
    end_of_test();
  end
endmodule

// ### core/cim_buffer.sv
// Two-entry valid/ready buffer between the capture logic and the stream engine.
// Assumes source and sink share the one clock; data held in flip-flops.
`timescale 1ns/1ns
module cim_buffer
  import cim_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire logic [DATA_W-1:0] inData,
  output logic                   outValid,
  input  wire logic              outReady,
  output logic      [DATA_W-1:0] outData
);

  logic [DATA_W-1:0]  mem_r [BUF_DEPTH];
  logic [BUF_IDX_W:0] count_r;
  logic [BUF_IDX_W-1:0] wrIdx_r;
  logic [BUF_IDX_W-1:0] rdIdx_r;
  logic               push;
  logic               pop;

  // Honest full and empty from the occupancy count
  assign inReady  = (count_r != 2'(BUF_DEPTH));
  assign outValid = (count_r != 2'h0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_r[rdIdx_r];

  // Storage write; no reset needed on the data itself
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wrIdx_r] <= inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrIdx_r <= '0;
      rdIdx_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrIdx_r <= wrIdx_r + 1'b1;
      end
      if (pop) begin
        rdIdx_r <= rdIdx_r + 1'b1;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ### core/cim_counter.sv
// Counter input engine: edge count, pulse-width, pulse and semi-period capture.
// Assumes source, gate, direction and sample clock are asynchronous pins; one clock.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Edge counting counts selected source edges only after arming.
// - Live count readable at any time without disturbing counting.
// - Active pause trigger blocks source edges; inactive lets them count.
// - Pause comes from gate; polarity chosen by configuration.
// - Buffered edge count samples the count on each active sample clock edge.
// - Samples are cumulative since arm; sample clock never clears count.
// - Configuration picks rising or falling sample clock edge.
// - Direction: always up, always down, or up/down from direction input.
// - Pulse-width counts source edges while gate pulse is active.
// - Arming during an active pulse skips it; start at next activation.
// - Single pulse-width stores count once at gate inactive, then stops.
// - Implicit buffered pulse-width stores count at each trailing gate edge.
// - Sample-clocked pulse-width stores last completed width on each sample after a completed pulse.
// - Sample-clocked pulse modes flag overrun when no pulse completed.
// - Pulse mode counts source edges in both gate high and low phases.
// - Implicit pulse stores at every gate edge, starting at chosen edge.
// - Sample-clocked pulse stores high and low ticks of last pulse.
// - Semi-period stores count between each pair of gate edges.
// - First stored phase selectable for implicit pulse and semi-period.
// - Pulse and semi-period share capture; only grouping differs.
// - Semi-period offers only implicit timing, no sample clock.
// - Buffered values drain to the host through a streaming port.
// - Count register is thirty-two bits wide.
module cim_counter
  import cim_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              sourcePin,
  input  wire logic              gatePin,
  input  wire logic              dirPin,
  input  wire logic              sampleClkPin,
  input  wire logic              arm,
  input  wire logic              disarm,
  input  wire logic [MODE_W-1:0] mode,
  input  wire logic              sourceFalling,
  input  wire logic              sampleFalling,
  input  wire logic              pauseOnHigh,
  input  wire logic              pauseEnable,
  input  wire logic              measureLow,
  input  wire logic              first_phase_select,
  input  wire logic              semi_period_first_phase_select,
  input  wire logic [DIR_W-1:0]  dirSelect,
  input  wire logic [CNT_W-1:0]  initialCount,
  output logic      [CNT_W-1:0]  countValue,
  output logic                   armed,
  output logic                   done,
  output logic                   overrun,
  output logic                   dropped,
  output logic                   streamValid,
  input  wire logic              streamReady,
  output logic      [DATA_W-1:0] streamData
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic [3:0] pinPrev_r;
  logic       srcS, gateS, dirS, sclkS;

  // Three flops per pin, two to synchronise and one for edge detect; the first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
      pinPrev_r <= 4'h0;
    end else begin
      pinMeta_r <= {sampleClkPin, dirPin, gatePin, sourcePin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  assign srcS  = pinSync_r[0];
  assign gateS = pinSync_r[1];
  assign dirS  = pinSync_r[2];
  assign sclkS = pinSync_r[3];

  logic srcEdge, gateRise, gateFall, gateEdge, sclkEdge;

  // Selectable source and sample clock polarity
  assign srcEdge  = sourceFalling ? (pinPrev_r[0] && !srcS) : (!pinPrev_r[0] && srcS);
  assign gateRise = !pinPrev_r[1] && gateS;
  assign gateFall = pinPrev_r[1] && !gateS;
  assign gateEdge = gateRise || gateFall;
  assign sclkEdge = sampleFalling ? (pinPrev_r[3] && !sclkS) : (!pinPrev_r[3] && sclkS);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic isEdge, isPw, isPulse, isSclkMode, gateActive, gateToActive, gateToIdle;

  assign isEdge     = (mode == MODE_EDGE_DEMAND) || (mode == MODE_EDGE_SCLK);
  assign isPw       = (mode == MODE_PW_SINGLE) || (mode == MODE_PW_IMPL)
                      || (mode == MODE_PW_SCLK);
  // Pulse and semi-period share one capture path
  assign isPulse    = (mode == MODE_PULSE_IMPL) || (mode == MODE_PULSE_SCLK)
                      || (mode == MODE_SEMI_IMPL);
  // Semi-period has no sampled variant in the mode set
  assign isSclkMode = (mode == MODE_PW_SCLK) || (mode == MODE_PULSE_SCLK);
  assign gateActive   = measureLow ? !gateS : gateS;
  assign gateToActive = measureLow ? gateFall : gateRise;
  assign gateToIdle   = measureLow ? gateRise : gateFall;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  cim_state_t state_r;
  logic       startPhase;
  logic       startEdge;

  // Chosen first phase: high first starts at a rising gate edge; sampled pairs
  // always open at a rise so every pair closes high then low
  assign startPhase = (mode == MODE_SEMI_IMPL)  ? semi_period_first_phase_select
                    : (mode == MODE_PULSE_SCLK) ? 1'b1
                                                : first_phase_select;
  assign startEdge  = isPulse ? (startPhase ? gateRise : gateFall) : gateToActive;

  // Edge modes run at once; gate modes wait for a clean start edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= CIM_IDLE;
    end else if (disarm) begin
      state_r <= CIM_IDLE;
    end else if (arm) begin
      state_r <= isEdge ? CIM_RUN : CIM_WAIT;
    end else begin
      unique case (state_r)
        CIM_IDLE: state_r <= CIM_IDLE;
        CIM_WAIT: begin
          if (startEdge) begin
            state_r <= CIM_RUN;
          end
        end
        CIM_RUN: begin
          if (mode == MODE_PW_SINGLE && gateToIdle) begin
            state_r <= CIM_DONE;
          end
        end
        CIM_DONE: state_r <= CIM_DONE;
      endcase
    end
  end

  assign armed = (state_r != CIM_IDLE);
  assign done  = (state_r == CIM_DONE);

  ////////////////////////////////////////////////////////////////////////////////
  // Count register

  logic             running;
  logic             paused;
  logic             countUp;
  logic             srcCounts;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             pwBoundary;

  assign running = (state_r == CIM_RUN);
  // Pause only applies to edge counting and comes from the gate level
  assign paused  = isEdge && pauseEnable && (pauseOnHigh ? gateS : !gateS);
  assign countUp = (dirSelect == DIR_UP) || ((dirSelect == DIR_EXT) && dirS);
  assign srcCounts = running && srcEdge && !paused
                     && (isEdge || isPulse || (isPw && gateActive));
  // Gate boundaries that close a measurement interval
  assign pwBoundary = running && (isPw ? gateToIdle : (isPulse && gateEdge));

  always_comb begin
    count_nxt = count_r;
    if (srcCounts) begin
      count_nxt = countUp ? count_r + 32'h0000_0001 : count_r - 32'h0000_0001;
    end
  end

  // Arm loads the initial value; sample clock never touches the count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= CNT_RESET;
    end else if (arm) begin
      count_r <= initialCount;
    end else if (isEdge) begin
      count_r <= count_nxt;
    end else if (pwBoundary || state_r == CIM_WAIT) begin
      count_r <= initialCount;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Live count needs no handshake; reading it has no side effect
  assign countValue = count_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Last completed measurement for sample-clocked modes

  logic [CNT_W-1:0] lastHigh_r;
  logic [CNT_W-1:0] lastLow_r;
  logic             fresh_r;
  logic             sampleTake;
  logic             pairClose;

  assign sampleTake = running && isSclkMode && sclkEdge;
  // A pulse completes when its trailing phase ends
  assign pairClose  = running && (isPw ? gateToIdle : (isPulse && gateRise));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastHigh_r <= CNT_RESET;
      lastLow_r  <= CNT_RESET;
    end else if (running && isPulse && gateFall) begin
      lastHigh_r <= count_nxt;
    end else if (running && isPulse && gateRise) begin
      lastLow_r  <= count_nxt;
    end else if (running && isPw && gateToIdle) begin
      lastHigh_r <= count_nxt;
    end
  end

  // Completion flag: new pulse wins over the sample's clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fresh_r <= 1'b0;
    end else if (arm) begin
      fresh_r <= 1'b0;
    end else if (pairClose) begin
      fresh_r <= 1'b1;
    end else if (sampleTake) begin
      fresh_r <= 1'b0;
    end
  end

  // Sticky overrun until the next arm; set wins over the arm clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (sampleTake && !fresh_r && !pairClose) begin
      overrun <= 1'b1;
    end else if (arm) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture into the buffer; sample-clocked pulse pairs go out as two words, high first

  logic              capValid;
  logic [DATA_W-1:0] capData;
  logic              capReady;
  logic              pendLow_r;
  logic [CNT_W-1:0]  pendWord_r;
  logic              implPush;

  assign implPush = running && (
      (mode == MODE_EDGE_SCLK && sclkEdge)
    || ((mode == MODE_PW_SINGLE || mode == MODE_PW_IMPL) && gateToIdle)
    || ((mode == MODE_PULSE_IMPL || mode == MODE_SEMI_IMPL) && gateEdge));

  // Word selection; bit 32 marks a high phase
  always_comb begin
    capValid = 1'b0;
    capData  = '0;
    if (pendLow_r) begin
      capValid = 1'b1;
      capData  = {1'b0, pendWord_r};
    end else if (implPush) begin
      capValid = 1'b1;
      capData  = {isPulse ? gateFall : !measureLow,
                  isEdge ? count_r : count_nxt};
    end else if (sampleTake && fresh_r) begin
      capValid = 1'b1;
      capData  = {1'b1, lastHigh_r};
    end
  end

  // Second half of a pulse pair waits one slot; drop is flagged, not stalled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendLow_r  <= 1'b0;
      pendWord_r <= CNT_RESET;
    end else if (arm) begin
      pendLow_r <= 1'b0;
    end else if (pendLow_r && capReady) begin
      pendLow_r <= 1'b0;
    end else if (!pendLow_r && !implPush && sampleTake && fresh_r
                 && mode == MODE_PULSE_SCLK && capReady) begin
      pendLow_r  <= 1'b1;
      pendWord_r <= lastLow_r;
    end
  end

  // Sticky loss flag: a capture with a full buffer cannot wait for the pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dropped <= 1'b0;
    end else if ((implPush || (sampleTake && fresh_r)) && (pendLow_r || !capReady)) begin
      dropped <= 1'b1;
    end else if (arm) begin
      dropped <= 1'b0;
    end
  end

  // Stream toward host memory through the two-entry buffer
  cim_buffer u_buf (
    .clock    (clock),
    .rst      (rst),
    .inValid  (capValid),
    .inReady  (capReady),
    .inData   (capData),
    .outValid (streamValid),
    .outReady (streamReady),
    .outData  (streamData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_NO_COUNT_UNARMED: assert property (@(posedge clock) disable iff (rst)
    (state_r == CIM_IDLE && !arm) |=> $stable(count_r))
    else $error("count moved while unarmed");

  AST_PAUSE_HOLDS: assert property (@(posedge clock) disable iff (rst)
    (paused && !arm && isEdge) |=> $stable(count_r))
    else $error("count moved while paused");

  AST_ARM_LOADS: assert property (@(posedge clock) disable iff (rst)
    arm |=> (count_r == $past(initialCount)))
    else $error("arm did not load initial count");

  AST_SCLK_NO_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (mode == MODE_EDGE_SCLK && running && sclkEdge && !srcEdge && !arm && !disarm)
      |=> (count_r == $past(count_r)))
    else $error("sample clock disturbed count");

  AST_EDGE_SAMPLE_PUSH: assert property (@(posedge clock) disable iff (rst)
    (mode == MODE_EDGE_SCLK && running && sclkEdge && !pendLow_r)
      |-> (capValid && capData[CNT_W-1:0] == count_r))
    else $error("sample clock edge not captured");

  AST_SINGLE_STOPS: assert property (@(posedge clock) disable iff (rst)
    (state_r == CIM_DONE && !arm) |-> !capValid)
    else $error("single pulse-width stored twice");

  AST_OVERRUN: assert property (@(posedge clock) disable iff (rst)
    (sampleTake && !fresh_r && !pairClose && !arm) |=> overrun)
    else $error("overrun not flagged");

  AST_DIR_DOWN: assert property (@(posedge clock) disable iff (rst)
    (srcCounts && dirSelect == DIR_DN && !arm && isEdge)
      |=> (count_r == $past(count_r) - 32'h0000_0001))
    else $error("down count wrong");

  AST_ARM_ACTIVE_WAITS: assert property (@(posedge clock) disable iff (rst)
    (arm && !isEdge && !disarm) |=> (state_r == CIM_WAIT && !capValid))
    else $error("armed measurement started without a start edge");

endmodule

// ### core/cim_pkg.sv
// Package for the counter input measurement engine: modes, field codes and constants.
// Assumes a single 250 MHz clock domain; all users import the whole package.
package cim_pkg;

  localparam int CNT_W      = 32;  // Count register width
  localparam int MODE_W     = 3;   // Width of the measurement mode field
  localparam int DIR_W      = 2;   // Width of the direction select field
  localparam int BUF_DEPTH  = 2;   // Entries of the output buffer
  localparam int BUF_IDX_W  = 1;   // Index width of the output buffer
  localparam int DATA_W     = 33;  // Word width: phase flag plus count
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;  // Count after reset

  // Measurement modes
  localparam logic [MODE_W-1:0] MODE_EDGE_DEMAND = 3'h0;
  localparam logic [MODE_W-1:0] MODE_EDGE_SCLK   = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PW_SINGLE   = 3'h2;
  localparam logic [MODE_W-1:0] MODE_PW_IMPL     = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PW_SCLK     = 3'h4;
  localparam logic [MODE_W-1:0] MODE_PULSE_IMPL  = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PULSE_SCLK  = 3'h6;
  localparam logic [MODE_W-1:0] MODE_SEMI_IMPL   = 3'h7;

  // Direction select
  localparam logic [DIR_W-1:0] DIR_UP  = 2'h0;
  localparam logic [DIR_W-1:0] DIR_DN  = 2'h1;
  localparam logic [DIR_W-1:0] DIR_EXT = 2'h2;

  // Measurement sequencer states
  typedef enum logic [1:0] {CIM_IDLE, CIM_WAIT, CIM_RUN, CIM_DONE} cim_state_t;

endpackage
